//--- sebs_consts.svh
// constants for the two-wire serial memory slave: control code, sizes, timing
// assumes inclusion by bare name from the slave module
`ifndef SEBS_CONSTS_SVH
`define SEBS_CONSTS_SVH

`define SEBS_CTRL_CODE 4'hA
`define SEBS_CTRL_SEL 3'h0
`define SEBS_ADDR_W 12
`define SEBS_PAGE_W 5
`define SEBS_PAGE_LAST 5'h1F
`define SEBS_BITS_PER_BYTE 4'h8
`define SEBS_TWR_NS 5000000
`define SEBS_MCLK_NS 8

`endif

//--- sebs_pkg.sv
// types for the two-wire serial memory slave
// assumes nothing beyond the constants header
`default_nettype none
package sebs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_ADRH,
    ST_ADRL,
    ST_WDATA,
    ST_READ
  } sebs_state_e;
endpackage
`default_nettype wire

//--- sebs_slave.sv
// two-wire bus slave for a 4096 x 8 memory with 32-byte page buffer
// assumes an external pull-up resolves the data wire from sda_oe_o and the master
// drives link_scl_i; bits are caught on the line clock, framing on mclk_i
// Function
// - data line changes only while clock is low, except start and stop
// - data fall while clock high is start; master starts every command
// - data rise while clock high is stop; master ends every operation
// - one clock pulse per bit; bit valid while stable through high phase
// - receiver acknowledges each byte on a ninth clock pulse
// - acknowledger holds data low through the whole ack high phase
// - no acknowledge at all while internal write cycle runs
// - read ends on master no-ack; slave releases data line high
// - control byte upper code 1010 and select bits zero
// - control byte low bit: one reads, zero writes
// - valid control byte is acknowledged, then read or write handling
// - write control byte followed by high then low address byte
// - byte write of three header bytes plus data; stop starts write cycle
// - page write buffers up to 32 bytes, committed only after stop
// - only five low address bits increment; overflow wraps in page
// - write-control polling is unacknowledged while busy, acknowledged after
// - address counter holds last accessed address plus one
// - read control byte acknowledged, then eight data bits shifted out
// - repeated start after address aborts write but keeps the pointer
// - master ack after a read byte requests the next sequential byte
// - read pointer wraps from top address to zero
`timescale 1ns/1ps
`default_nettype none
`include "sebs_consts.svh"

module sebs_slave #(
  parameter int TWR_CYC = `SEBS_TWR_NS / `SEBS_MCLK_NS
) (
  input wire logic mclk_i,      // system clock, 125 MHz
  input wire logic rst_i,       // asynchronous reset, active high
  input wire logic link_scl_i,  // serial clock from the master
  input wire logic sda_i,       // serial data wire level
  output logic sda_o,           // serial data drive value, always low
  output logic sda_oe_o,        // high while pulling the data wire low
  output logic busy_o           // internal write cycle running
);

  localparam int TW = $clog2(TWR_CYC + 1);
  localparam int AW = `SEBS_ADDR_W;
  localparam int PW = `SEBS_PAGE_W;
  localparam int BW = TW + PW + 1;

  // link domain: catch each bit on the rising clock edge
  logic cap_bit;
  logic cap_tog;

  always_ff @(posedge link_scl_i or posedge rst_i) begin
    if (rst_i) begin
      cap_bit <= 1'b0;
      cap_tog <= 1'b0;
    end else begin
      cap_bit <= sda_i;
      cap_tog <= ~cap_tog;
    end
  end

  // three-stage synchronisers, a change counts once stages two and three agree
  logic [2:0] scl_sy, sda_sy, tog_sy, bit_sy;
  logic scl_f, sda_f, tog_f, bit_f;
  logic scl_q, sda_q, tog_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_sy <= 3'h7;
      sda_sy <= 3'h7;
      tog_sy <= 3'h0;
      bit_sy <= 3'h0;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      tog_f <= 1'b0;
      bit_f <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      tog_q <= 1'b0;
    end else begin
      scl_sy <= {scl_sy[1:0], link_scl_i};
      sda_sy <= {sda_sy[1:0], sda_i};
      tog_sy <= {tog_sy[1:0], cap_tog};
      bit_sy <= {bit_sy[1:0], cap_bit};
      if (scl_sy[1] == scl_sy[2]) scl_f <= scl_sy[2];
      if (sda_sy[1] == sda_sy[2]) sda_f <= sda_sy[2];
      if (tog_sy[1] == tog_sy[2]) tog_f <= tog_sy[2];
      if (bit_sy[1] == bit_sy[2]) bit_f <= bit_sy[2];
      scl_q <= scl_f;
      sda_q <= sda_f;
      tog_q <= tog_f;
    end
  end

  // bit event is delayed one cycle so the data bit has settled behind it
  logic bit_ev;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_ev <= 1'b0;
    end else begin
      bit_ev <= tog_f ^ tog_q;
    end
  end

  logic start_det, stop_det, scl_fall;
  assign start_det = scl_f && scl_q && sda_q && !sda_f;
  assign stop_det = scl_f && scl_q && !sda_q && sda_f;
  assign scl_fall = scl_q && !scl_f;

  sebs_pkg::sebs_state_e state;
  logic [3:0] bit_cnt;
  logic in_ack;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic [AW-1:0] addr;
  logic [31:0] pvalid;
  logic committing;
  logic [PW-1:0] cidx;
  logic [AW-PW-1:0] cpage;
  logic [TW-1:0] twr_cnt;
  logic busy;
  logic ack_fall, end_fall, ctrl_ok, commit_done;
  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] pbuf [0:(1<<PW)-1];

  assign busy = committing || (twr_cnt != '0);
  assign ack_fall = scl_fall && (state != sebs_pkg::ST_IDLE) && !in_ack
                    && (bit_cnt == `SEBS_BITS_PER_BYTE);
  assign end_fall = scl_fall && in_ack;
  assign ctrl_ok = (shreg[7:4] == `SEBS_CTRL_CODE) && (shreg[3:1] == `SEBS_CTRL_SEL);
  assign commit_done = committing && (cidx == `SEBS_PAGE_LAST);

  // protocol engine
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= sebs_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      in_ack <= 1'b0;
      shreg <= 8'h00;
      tx <= 8'h00;
      addr <= '0;
      sda_oe_o <= 1'b0;
    end else if (start_det) begin
      state <= sebs_pkg::ST_CTRL;
      bit_cnt <= 4'h0;
      in_ack <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (stop_det) begin
      state <= sebs_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      in_ack <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      case (state)
        sebs_pkg::ST_IDLE: begin
          sda_oe_o <= 1'b0;
        end
        default: begin
          if (bit_ev && !in_ack && bit_cnt < `SEBS_BITS_PER_BYTE) begin
            shreg <= {shreg[6:0], bit_f};
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (bit_ev && in_ack && state == sebs_pkg::ST_READ && bit_f) begin
            state <= sebs_pkg::ST_IDLE;
          end
          if (ack_fall) begin
            in_ack <= 1'b1;
            sda_oe_o <= 1'b0;
            case (state)
              sebs_pkg::ST_CTRL: begin
                if (ctrl_ok && !busy) begin
                  sda_oe_o <= 1'b1;
                  state <= shreg[0] ? sebs_pkg::ST_READ : sebs_pkg::ST_ADRH;
                end else begin
                  state <= sebs_pkg::ST_IDLE;
                end
              end
              sebs_pkg::ST_ADRH: begin
                addr[AW-1:8] <= shreg[AW-9:0];
                sda_oe_o <= 1'b1;
                state <= sebs_pkg::ST_ADRL;
              end
              sebs_pkg::ST_ADRL: begin
                addr[7:0] <= shreg;
                sda_oe_o <= 1'b1;
                state <= sebs_pkg::ST_WDATA;
              end
              sebs_pkg::ST_WDATA: begin
                addr[PW-1:0] <= addr[PW-1:0] + 5'h01;
                sda_oe_o <= 1'b1;
              end
              default: begin
                sda_oe_o <= 1'b0; // master acknowledges here
              end
            endcase
          end else if (end_fall) begin
            in_ack <= 1'b0;
            bit_cnt <= 4'h0;
            if (state == sebs_pkg::ST_READ) begin
              tx <= mem[addr];
              addr <= addr + 12'h001;
              sda_oe_o <= !mem[addr][7];
            end else begin
              sda_oe_o <= 1'b0;
            end
          end else if (scl_fall && state == sebs_pkg::ST_READ && !in_ack) begin
            sda_oe_o <= !tx[3'h7 - bit_cnt[2:0]];
          end
        end
      endcase
    end
  end

  // page buffer: which slots hold fresh data
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pvalid <= 32'h0000_0000;
    end else if (commit_done || (start_det && !committing)) begin
      pvalid <= 32'h0000_0000; // an aborted write discards buffered data
    end else if (ack_fall && state == sebs_pkg::ST_WDATA) begin
      pvalid[addr[PW-1:0]] <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (ack_fall && state == sebs_pkg::ST_WDATA) begin
      pbuf[addr[PW-1:0]] <= shreg;
    end
  end

  // commit after stop, then self-timed write cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      committing <= 1'b0;
      cidx <= 5'h00;
      cpage <= '0;
      twr_cnt <= '0;
      busy_o <= 1'b0;
    end else begin
      busy_o <= busy;
      if (stop_det && state == sebs_pkg::ST_WDATA && pvalid != 32'h0000_0000) begin
        committing <= 1'b1;
        cidx <= 5'h00;
        cpage <= addr[AW-1:PW];
        twr_cnt <= TW'(TWR_CYC);
      end else if (commit_done) begin
        committing <= 1'b0;
      end else if (committing) begin
        cidx <= cidx + 5'h01;
      end else if (twr_cnt != '0) begin
        twr_cnt <= twr_cnt - TW'(1);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (committing && pvalid[cidx]) begin
      mem[{cpage, cidx}] <= pbuf[cidx];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0; // open drain: only ever pulls low
    end
  end

  // length of the running write cycle, watched by the bound checks
  logic [BW-1:0] busy_len;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_len <= '0;
    end else if (!busy) begin
      busy_len <= '0;
    end else begin
      busy_len <= busy_len + BW'(1);
    end
  end

  // checks
  sequence s_nack_seen;
    bit_ev && in_ack && state == sebs_pkg::ST_READ && bit_f;
  endsequence

  sequence s_released;
    state == sebs_pkg::ST_IDLE ##1 !sda_oe_o;
  endsequence

  a_drive_change: assert property (@(posedge mclk_i) disable iff (rst_i)
    $changed(sda_oe_o) |-> $past(scl_fall || start_det || stop_det))
    else $error("data drive changed outside clock low");
  a_start_frame: assert property (@(posedge mclk_i) disable iff (rst_i)
    start_det |=> state == sebs_pkg::ST_CTRL && bit_cnt == 4'h0)
    else $error("start did not open a control byte");
  a_stop_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
    stop_det |=> state == sebs_pkg::ST_IDLE && !sda_oe_o)
    else $error("stop did not return to idle");
  a_ack_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    (in_ack && sda_oe_o && !scl_fall && !start_det && !stop_det) |=> sda_oe_o)
    else $error("acknowledge dropped early");
  a_busy_noack: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ack_fall && busy) |=> !sda_oe_o)
    else $error("acknowledge given during write cycle");
  a_nack_release: assert property (@(posedge mclk_i) disable iff (rst_i)
    (s_nack_seen and (!start_det && !stop_det && !scl_fall)) |=> s_released)
    else $error("no-ack did not release the line");
  a_ctrl_reject: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ack_fall && state == sebs_pkg::ST_CTRL && !ctrl_ok)
    |=> state == sebs_pkg::ST_IDLE && !sda_oe_o)
    else $error("bad control byte accepted");
  a_ctrl_dir: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ack_fall && state == sebs_pkg::ST_CTRL && ctrl_ok && !busy) |=> sda_oe_o
    && state == ($past(shreg[0]) ? sebs_pkg::ST_READ : sebs_pkg::ST_ADRH))
    else $error("control byte direction mishandled");
  a_addr_high: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ack_fall && state == sebs_pkg::ST_ADRH) |=> addr[11:8] == $past(shreg[3:0]))
    else $error("high address load wrong");
  a_page_wrap: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ack_fall && state == sebs_pkg::ST_WDATA) |=> addr[11:5] == $past(addr[11:5])
    && addr[4:0] == $past(addr[4:0]) + 5'h01)
    else $error("page address increment wrong");
  a_read_next: assert property (@(posedge mclk_i) disable iff (rst_i)
    (end_fall && state == sebs_pkg::ST_READ && !start_det && !stop_det)
    |=> addr == $past(addr) + 12'h001)
    else $error("read pointer did not advance");
  a_stop_commit: assert property (@(posedge mclk_i) disable iff (rst_i)
    (stop_det && state == sebs_pkg::ST_WDATA && pvalid != 32'h0000_0000)
    |=> committing ##1 busy_o)
    else $error("stop did not start the write cycle");
  a_addr_low: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ack_fall && state == sebs_pkg::ST_ADRL) |=> addr[7:0] == $past(shreg))
    else $error("low address load wrong");
  a_data_ack: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ack_fall && state == sebs_pkg::ST_WDATA) |=> sda_oe_o && in_ack)
    else $error("data byte not acknowledged");
  a_read_bit: assert property (@(posedge mclk_i) disable iff (rst_i)
    (scl_fall && state == sebs_pkg::ST_READ && !in_ack && bit_cnt < `SEBS_BITS_PER_BYTE)
    |=> sda_oe_o == !$past(tx[3'h7 - bit_cnt[2:0]]))
    else $error("read bit driven wrong");
  a_master_turn: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ack_fall && state == sebs_pkg::ST_READ) |=> !sda_oe_o && in_ack)
    else $error("line not released for the master answer");
  a_idle_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state == sebs_pkg::ST_IDLE && $past(state) == sebs_pkg::ST_IDLE) |-> !sda_oe_o)
    else $error("data line pulled while idle");
  a_commit_step: assert property (@(posedge mclk_i) disable iff (rst_i)
    (committing && !commit_done) |=> committing && cidx == $past(cidx) + 5'h01)
    else $error("page commit skipped a slot");
  a_busy_bound: assert property (@(posedge mclk_i) disable iff (rst_i)
    busy |-> busy_len < BW'(TWR_CYC + (1 << PW)))
    else $error("write cycle ran too long");
  a_busy_full: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(busy) |-> $past(busy_len) == BW'(TWR_CYC + (1 << PW) - 1))
    else $error("write cycle ended early");
  a_bit_count: assert property (@(posedge mclk_i) disable iff (rst_i)
    (bit_ev && !in_ack && state != sebs_pkg::ST_IDLE && !start_det && !stop_det
    && bit_cnt < `SEBS_BITS_PER_BYTE) |=> bit_cnt == $past(bit_cnt) + 4'h1)
    else $error("bit count did not advance");
  a_poll_busy: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ack_fall && state == sebs_pkg::ST_CTRL && busy) |=> state == sebs_pkg::ST_IDLE)
    else $error("busy poll was not turned away");
  a_ack_end: assert property (@(posedge mclk_i) disable iff (rst_i)
    (end_fall && state != sebs_pkg::ST_READ) |=> !sda_oe_o)
    else $error("acknowledge not released after its pulse");

endmodule // sebs_slave
`default_nettype wire

//--- sebs_master_model.sv
// two-wire bus master model for the memory slave bench
// assumes a pull-up: the data wire is low only while a party pulls it
`timescale 1ns/1ps
`default_nettype none
module sebs_master_model #(
  parameter int HALF_NS = 165,
  parameter int HOLD_NS = 40
) (
  input wire logic sda_i, // resolved data wire
  output logic scl_o,     // serial clock, still between frames
  output logic sda_oe_o   // high while pulling data low
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // start from idle or repeated start
  task automatic start_cond();
    sda_oe_o = 1'b0;
    #HALF_NS scl_o = 1'b1;
    #HALF_NS sda_oe_o = 1'b1;
    #HALF_NS scl_o = 1'b0;
    #HALF_NS;
  endtask
  // a frame ends here unless a repeated start follows, length chosen by the master
  task automatic stop_cond();
    #HOLD_NS sda_oe_o = 1'b1;
    #HALF_NS scl_o = 1'b1;
    #HALF_NS sda_oe_o = 1'b0;
    #HALF_NS;
  endtask
  // one pulse per bit, data moved only after the hold with clock low
  task automatic pulse(output logic v);
    #HALF_NS scl_o = 1'b1;
    #HALF_NS v = sda_i;
    scl_o = 1'b0;
    #HOLD_NS;
  endtask
  // msb first, ninth pulse for the slave's answer
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      sda_oe_o = !b[i];
      pulse(v);
    end
    sda_oe_o = 1'b0;
    pulse(v);
    ack = !v;
  endtask
  // ack asks for the next byte, no-ack ends the read
  task automatic recv_byte(output logic [7:0] b, output logic rel, input logic ack_en);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      pulse(v);
      b[i] = v;
    end
    sda_oe_o = ack_en;
    pulse(v);
    rel = v;
    sda_oe_o = 1'b0;
  endtask
endmodule // sebs_master_model
`default_nettype wire

//--- sebs_slave_test.sv
// self-checking bench for the two-wire memory slave
// assumes the master model and an ideal pull-up on the data wire
`timescale 1ns/1ps
`default_nettype none
module sebs_slave_test;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  wire logic scl;
  wire logic m_oe;
  wire logic sda_oe;
  wire logic busy;
  wire logic sda_drv;
  wire logic sda = !m_oe && (sda_oe ? sda_drv : 1'b1);
  int mismatches = 0;
  int tests_run = 0;
  always #4 mclk = !mclk;
  sebs_slave #(.TWR_CYC(1000)) dut_u (
    .mclk_i(mclk), .rst_i(rst), .link_scl_i(scl), .sda_i(sda),
    .sda_o(sda_drv), .sda_oe_o(sda_oe), .busy_o(busy));
  sebs_master_model m_u (.sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic exp);
    logic ack;
    m_u.send_byte(b, ack);
    check({7'h0, ack}, {7'h0, exp});
  endtask
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    check({7'h0, busy}, {7'h0, v});
  endtask
  // two data bytes, junk in the ignored address nibble, a poll during the write and one after
  task automatic write_mem(input logic [11:0] a, input logic [7:0] d0, input logic [7:0] d1);
    m_u.start_cond();
    send(8'hA0, 1'b1);
    send({4'hF, a[11:8]}, 1'b1);
    send(a[7:0], 1'b1);
    send(d0, 1'b1);
    send(d1, 1'b1);
    m_u.stop_cond();
    wait_busy(1'b1);
    m_u.start_cond();
    send(8'hA0, 1'b0);
    m_u.stop_cond();
    wait_busy(1'b0);
    m_u.start_cond();
    send(8'hA0, 1'b1);
    m_u.stop_cond();
  endtask
  task automatic read_at(input logic [11:0] a, input logic [7:0] e0, input logic seq,
                         input logic [7:0] e1);
    logic [7:0] b;
    logic rel;
    m_u.start_cond();
    send(8'hA0, 1'b1);
    send({4'h0, a[11:8]}, 1'b1);
    send(a[7:0], 1'b1);
    m_u.start_cond();
    send(8'hA1, 1'b1);
    m_u.recv_byte(b, rel, seq);
    check(b, e0);
    if (seq) begin
      m_u.recv_byte(b, rel, 1'b0);
      check(b, e1);
    end
    check({7'h0, rel}, 8'h01);
    m_u.stop_cond();
  endtask
  task automatic read_cur(input logic [7:0] e);
    logic [7:0] b;
    logic rel;
    m_u.start_cond();
    send(8'hA1, 1'b1);
    m_u.recv_byte(b, rel, 1'b0);
    m_u.stop_cond();
    check(b, e);
    check({7'h0, rel}, 8'h01);
  endtask
  // wrong select bits, then wrong code; following byte must be ignored
  task automatic bad_ctrl();
    logic [7:0] codes [2];
    codes = '{8'hA2, 8'h20};
    for (int i = 0; i < 2; i++) begin
      m_u.start_cond();
      send(codes[i], 1'b0);
      send(8'hA0, 1'b0);
      m_u.stop_cond();
    end
    m_u.start_cond();
    send(8'hA0, 1'b1);
    m_u.stop_cond();
    check({7'h0, busy}, 8'h00);
  endtask
  initial begin
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    repeat (10) @(negedge mclk);
    write_mem(12'h123, 8'h5A, 8'hC3);
    read_at(12'h123, 8'h5A, 1'b0, 8'h00);
    read_cur(8'hC3);
    write_mem(12'hFFF, 8'h11, 8'h22);
    write_mem(12'h000, 8'h33, 8'h44);
    read_at(12'hFFF, 8'h11, 1'b1, 8'h33);
    read_at(12'hFE0, 8'h22, 1'b0, 8'h00);
    bad_ctrl();
    end_sim();
  end
  initial begin
    #500000;
    mismatches++;
    end_sim();
  end
endmodule // sebs_slave_test
`default_nettype wire
